// ===== logic/dcd_core.sv
// command decode, burst column order and clock-enable state logic
`timescale 1ns/10ps
`default_nettype none

module dcd_core (
  input  wire logic                     CORE_CLK_IN,      // device clock, rising edge
  input  wire logic                     RST_IN,           // asynchronous reset, high
  input  wire logic                     CKE_IN,           // clock enable pin
  input  wire logic                     CS_N_IN,          // chip select, low active
  input  wire logic                     RAS_N_IN,         // row strobe, low active
  input  wire logic                     CAS_N_IN,         // column strobe, low active
  input  wire logic                     WE_N_IN,          // write enable, low active
  input  wire logic [dcd_pkg::BA_W-1:0] BA_IN,            // bank address
  input  wire logic [dcd_pkg::ADDR_W-1:0] ADDR_IN,        // address bus
  input  wire logic                     ODT_IN,           // termination request
  input  wire logic                     OTF_EN_IN,        // per-command burst length
  input  wire logic                     FIXED_CHOP_IN,    // fixed length is chop-4
  input  wire logic                     INTERLEAVE_IN,    // stored burst type
  input  wire logic                     BANKS_OPEN_IN,    // any bank still open
  output logic                          CMD_VALID_OUT,    // decoded command pulse
  output logic [3:0]                    CMD_CODE_OUT,     // decoded command code
  output logic [dcd_pkg::BA_W-1:0]      CMD_BA_OUT,       // bank of command
  output logic [dcd_pkg::ADDR_W-1:0]    CMD_ADDR_OUT,     // address of command
  output logic                          CMD_AP_OUT,       // auto precharge
  output logic                          CMD_CHOP_OUT,     // chop-4 burst
  output logic                          BURST_ACTIVE_OUT, // beat slot active
  output logic                          BURST_WRITE_OUT,  // slot belongs to a write
  output logic                          DQ_OE_OUT,        // data/strobe drivers on
  output logic [2:0]                    BURST_COL_OUT,    // column of this beat
  output logic [1:0]                    PWR_STATE_OUT,    // power state code
  output logic                          ODT_ACTIVE_OUT,   // termination applied
  output logic                          CKE_HOLD_ERR_OUT, // enable changed too soon
  output logic                          MRD_BUSY_OUT      // mode-set delay running
);
  import dcd_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // pins come from the controller; two flops before any logic reads them
  dcd_pins_t pins_s1;   // first stage, read only by the second
  dcd_pins_t pins;      // stable sampled pins
  // idle pin pattern; resetting to it keeps a false enable edge out of the
  // decode, at the cost of a power-down entry if enable is held low after reset
  localparam dcd_pins_t PINS_IDLE = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                      we_n: 1'b1, ba: '0, addr: '0};
  logic      odt_s1;    // first stage of termination request
  logic      odt_s2;    // stable termination request

  // ----------------------------------------
  // block state
  // ----------------------------------------
  typedef struct packed {
    logic              cke_prev;   // enable level at previous edge
    dcd_pwr_t          pwr;        // power state
    dcd_event_t        ev;         // decoded command pulse
    logic              b_act;      // burst running
    logic              b_wr;       // running burst is a write
    logic              b_chop;     // running burst is chop-4
    logic              b_il;       // interleave order latched
    logic [2:0]        b_start;    // starting column
    logic [BEAT_W-1:0] b_beat;     // current beat slot
    logic [CNT_W-1:0]  cke_cnt;    // edges since last enable change
    logic              cke_err;    // enable changed before minimum
    logic [CNT_W-1:0]  mrd_cnt;    // mode-set delay remaining
  } dcd_state_t;

  dcd_state_t st;
  dcd_state_t next_st;

  // ----------------------------------------
  // column order function
  // ----------------------------------------
  // sequential wraps within a nibble, interleave xors; bit 2 flips for
  // the second half of an eight-beat burst
  function automatic logic [2:0] col_of(input logic [2:0] start,
                                        input logic [2:0] beat,
                                        input logic       il);
    logic [1:0] low;
    low = il ? (start[1:0] ^ beat[1:0]) : 2'(start[1:0] + beat[1:0]);
    return {start[2] ^ beat[2], low};
  endfunction : col_of

  // ----------------------------------------
  // synchroniser flops
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      // enable high and deselect, the idle levels of the pins
      pins_s1 <= PINS_IDLE;
      pins    <= PINS_IDLE;
      odt_s1  <= 1'b0;
      odt_s2  <= 1'b0;
    end
    else
    begin
      pins_s1 <= '{cke: CKE_IN, cs_n: CS_N_IN, ras_n: RAS_N_IN, cas_n: CAS_N_IN,
                   we_n: WE_N_IN, ba: BA_IN, addr: ADDR_IN};
      pins    <= pins_s1;
      odt_s1  <= ODT_IN;
      odt_s2  <= odt_s1;
    end
  end

  // ----------------------------------------
  // decode and state update
  // ----------------------------------------
  logic       is_nop;    // nop or deselect on the pins
  logic       chop_sel;  // chop chosen for a read or write
  dcd_cmd_t   dec;       // command decoded at this edge

  always_comb
  begin
    next_st = st;
    // deselect and nop fold together, pins behind cs don't matter
    is_nop  = pins.cs_n | (pins.ras_n & pins.cas_n & pins.we_n);
    // per-command length only when enabled; otherwise bit 12 is ignored
    chop_sel = OTF_EN_IN ? ~pins.addr[BC_BIT] : FIXED_CHOP_IN;
    dec     = DCD_CMD_NOP;
    // ---- command table, enable level compared across edges
    unique case ({st.cke_prev, pins.cke})
      2'b11:
      begin
        if (is_nop)
          dec = DCD_CMD_NOP;
        else
          unique case ({pins.ras_n, pins.cas_n, pins.we_n})
            3'b000: dec = DCD_CMD_MRS;
            3'b001: dec = DCD_CMD_REF;
            3'b011: dec = DCD_CMD_ACT;
            3'b010: dec = pins.addr[AP_BIT] ? DCD_CMD_PREA : DCD_CMD_PRE;
            3'b110: dec = pins.addr[AP_BIT] ? DCD_CMD_ZQL : DCD_CMD_ZQS;
            3'b100: dec = DCD_CMD_WR;
            3'b101: dec = DCD_CMD_RD;
            default: dec = DCD_CMD_NOP;
          endcase
      end
      2'b10:
      begin
        // refresh with enable falling: self refresh; nop: power down
        if (!pins.cs_n && !pins.ras_n && !pins.cas_n && pins.we_n)
          dec = DCD_CMD_SRE;
        else if (is_nop)
          dec = DCD_CMD_PDE;
        else
          dec = DCD_CMD_ILL;
      end
      2'b01:
        dec = is_nop ? ((st.pwr == DCD_PWR_SR) ? DCD_CMD_SRX : DCD_CMD_PDX)
                     : DCD_CMD_ILL;
      2'b00:
        dec = DCD_CMD_HOLD;
    endcase
    // ---- event pulse
    next_st.ev.valid = (dec != DCD_CMD_NOP) && (dec != DCD_CMD_HOLD);
    next_st.ev.cmd   = dec;
    next_st.ev.ba    = pins.ba;
    next_st.ev.addr  = pins.addr;
    next_st.ev.ap    = pins.addr[AP_BIT];
    next_st.ev.chop  = chop_sel;
    // ---- power state
    unique case (dec)
      DCD_CMD_SRE: next_st.pwr = DCD_PWR_SR;
      // banks judged at the entry edge itself, even while a burst is still running
      DCD_CMD_PDE: next_st.pwr = BANKS_OPEN_IN ? DCD_PWR_APD : DCD_PWR_PPD;
      DCD_CMD_SRX, DCD_CMD_PDX: next_st.pwr = DCD_PWR_ON;
      default: next_st.pwr = st.pwr;
    endcase
    // ---- burst engine; nothing cuts a running burst
    if (st.b_act)
    begin
      next_st.b_beat = st.b_beat + 3'h1;
      if (st.b_beat == LAST_BEAT)
        next_st.b_act = 1'b0;
    end
    else if (dec == DCD_CMD_RD || dec == DCD_CMD_WR)
    begin
      next_st.b_act  = 1'b1;
      next_st.b_wr   = (dec == DCD_CMD_WR);
      next_st.b_chop = chop_sel;
      next_st.b_il   = INTERLEAVE_IN;
      next_st.b_beat = '0;
      // reads start anywhere; writes keep only bit 2, and only for chop
      if (dec == DCD_CMD_RD)
        next_st.b_start = pins.addr[2:0];
      else
        next_st.b_start = {chop_sel & pins.addr[2], 2'b00};
    end
    // ---- clock-enable hold counter
    if (pins.cke != st.cke_prev)
    begin
      next_st.cke_cnt = 8'h01;
      if (st.cke_cnt < CKE_MIN_CYC)
        next_st.cke_err = 1'b1;
    end
    else if (st.cke_cnt != 8'hff)
      next_st.cke_cnt = st.cke_cnt + 8'h01;
    // ---- mode-set delay counter
    if (dec == DCD_CMD_MRS)
      next_st.mrd_cnt = MRD_CYC;
    else if (st.mrd_cnt != 8'h00)
      next_st.mrd_cnt = st.mrd_cnt - 8'h01;
    next_st.cke_prev = pins.cke;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      st         <= '0;
      st.pwr     <= DCD_PWR_ON;
      st.b_start <= COL_RST;
      st.cke_cnt <= 8'hff;
      st.cke_prev <= 1'b1;  // matches the idle pins, so no exit is seen
    end
    else
      st <= next_st;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic chop_tail;  // beat in the silent half of a chop
  assign chop_tail = st.b_chop && (st.b_beat > CHOP_LAST);

  assign CMD_VALID_OUT    = st.ev.valid;
  assign CMD_CODE_OUT     = st.ev.cmd;
  assign CMD_BA_OUT       = st.ev.ba;
  assign CMD_ADDR_OUT     = st.ev.addr;
  assign CMD_AP_OUT       = st.ev.ap;
  assign CMD_CHOP_OUT     = st.ev.chop;
  assign BURST_ACTIVE_OUT = st.b_act;
  assign BURST_WRITE_OUT  = st.b_wr;
  // read drivers only, and dark in the tail of a chop
  assign DQ_OE_OUT        = st.b_act && !st.b_wr && !chop_tail;
  // writes run straight, so order flag is ignored for them
  assign BURST_COL_OUT    = col_of(st.b_start, st.b_beat, st.b_il & ~st.b_wr);
  assign PWR_STATE_OUT    = st.pwr;
  // termination never steers the decode above
  assign ODT_ACTIVE_OUT   = odt_s2 && (st.pwr != DCD_PWR_SR);
  assign CKE_HOLD_ERR_OUT = st.cke_err;
  assign MRD_BUSY_OUT     = st.mrd_cnt != 8'h00;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_read_start;
    !st.b_act && dec == DCD_CMD_RD;
  endsequence

  property p_burst_len;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      $rose(st.b_act) |-> st.b_act [*8] ##1 !st.b_act;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst not eight slots");

  property p_chop_tristate;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (s_read_start and chop_sel) |=> DQ_OE_OUT [*4] ##1 !DQ_OE_OUT [*4];
  endproperty
  a_chop_tristate: assert property (p_chop_tristate) else $error("chop drive");

  property p_read_first_col;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      s_read_start |=> BURST_COL_OUT == $past(pins.addr[2:0]);
  endproperty
  a_read_first_col: assert property (p_read_first_col) else $error("first column");

  property p_write_col;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (st.b_act && st.b_wr) |-> BURST_COL_OUT[1:0] == st.b_beat[1:0];
  endproperty
  a_write_col: assert property (p_write_col) else $error("write order");

  property p_sre;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      dec == DCD_CMD_SRE |=> PWR_STATE_OUT == DCD_PWR_SR;
  endproperty
  a_sre: assert property (p_sre) else $error("self refresh entry");

  property p_hold_low;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (!st.cke_prev && !pins.cke) |=> $stable(PWR_STATE_OUT);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("low power left");

  property p_nop_quiet;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (st.cke_prev && pins.cke && pins.cs_n) |=> !CMD_VALID_OUT;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("deselect decoded");

  property p_odt_sr;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      PWR_STATE_OUT == DCD_PWR_SR |-> !ODT_ACTIVE_OUT;
  endproperty
  a_odt_sr: assert property (p_odt_sr) else $error("termination in self refresh");

  property p_pde;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (dec == DCD_CMD_PDE && !BANKS_OPEN_IN) |=> PWR_STATE_OUT == DCD_PWR_PPD;
  endproperty
  a_pde: assert property (p_pde) else $error("power down kind");

  property p_cke_hold_err;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (pins.cke != st.cke_prev && st.cke_cnt < CKE_MIN_CYC) |=> CKE_HOLD_ERR_OUT;
  endproperty
  a_cke_hold_err: assert property (p_cke_hold_err) else $error("enable hold");

  property p_mrd_busy;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      dec == DCD_CMD_MRS |=> MRD_BUSY_OUT [*4];
  endproperty
  a_mrd_busy: assert property (p_mrd_busy) else $error("mode-set delay");

endmodule : dcd_core

`default_nettype wire

// ===== logic/dcd_pkg.sv
// package for the command decode and clock-enable state block
package dcd_pkg;

  // ----------------------------------------
  // field positions and widths
  // ----------------------------------------
  localparam int BA_W       = 3;           // bank address width
  localparam int ADDR_W     = 16;          // address bus width
  localparam int AP_BIT     = 10;          // auto precharge / all banks bit
  localparam int BC_BIT     = 12;          // burst chop bit, low = chop
  localparam int BEATS      = 8;           // beat slots in a burst window
  localparam int BEAT_W     = 3;           // beat counter width
  localparam logic [BEAT_W-1:0] LAST_BEAT = 3'h7;  // final beat slot
  localparam logic [BEAT_W-1:0] CHOP_LAST = 3'h3;  // last driven beat of chop
  localparam logic [2:0] COL_RST    = 3'h0; // column reset value

  // ----------------------------------------
  // timing counts in whole clock edges
  // ----------------------------------------
  localparam int CNT_W                 = 8;     // width of hold counters
  localparam logic [CNT_W-1:0] CKE_MIN_CYC = 8'h03; // default clock-enable hold
  localparam logic [CNT_W-1:0] MRD_CYC     = 8'h04; // default mode-set delay

  // ----------------------------------------
  // decoded commands and power states
  // ----------------------------------------
  typedef enum logic [3:0] {
    DCD_CMD_NOP, DCD_CMD_MRS, DCD_CMD_REF, DCD_CMD_ACT, DCD_CMD_PRE,
    DCD_CMD_PREA, DCD_CMD_ZQL, DCD_CMD_ZQS, DCD_CMD_WR, DCD_CMD_RD,
    DCD_CMD_SRE, DCD_CMD_SRX, DCD_CMD_PDE, DCD_CMD_PDX, DCD_CMD_HOLD,
    DCD_CMD_ILL
  } dcd_cmd_t;

  typedef enum logic [1:0] {
    DCD_PWR_ON, DCD_PWR_PPD, DCD_PWR_APD, DCD_PWR_SR
  } dcd_pwr_t;

  // command pins as sampled at one rising edge
  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } dcd_pins_t;

  // one decoded command, pulsed for a cycle
  typedef struct packed {
    logic              valid;
    dcd_cmd_t          cmd;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic              ap;
    logic              chop;
  } dcd_event_t;

  // burst beat output
  typedef struct packed {
    logic       active;
    logic       is_write;
    logic       drive;
    logic [2:0] col;
  } dcd_beat_t;

endpackage : dcd_pkg

// ===== test/dcd_ctrl_model.sv
// controller-side model that drives the command, bank, address and enable pins
`timescale 1ns/10ps
`default_nettype none
module dcd_ctrl_model #(
  parameter int XS_CYC = 5                   // quiet edges kept after a wake-up
) (
  input  wire logic              clk_in,     // device clock
  output var  dcd_pkg::dcd_pins_t pins_out   // pins as the controller drives them
);
  import dcd_pkg::*;
  logic [CNT_W-1:0] hold_cnt;                // edges the present enable level was seen
  logic [CNT_W-1:0] mrs_cnt;                 // edges since the last mode set
  logic             last_cke;                // enable level at the previous edge
  logic             busy;                    // a command sits on the pins
  logic             woke;                    // enable just rose, quiet period owed

  initial
  begin
    pins_out = '0;
    pins_out.cke = 1'b1;
    pins_out.cs_n = 1'b1;
    {busy, woke, last_cke} = 3'h1;
    hold_cnt = '0;
    mrs_cnt = 8'hff;
  end

  // ----------------------------------------
  // edge counters and idle pattern
  // ----------------------------------------
  // deselected lines toggle so a stale level never looks like a command
  always @(posedge clk_in)
  begin
    last_cke <= pins_out.cke;
    hold_cnt <= (pins_out.cke == last_cke) ? hold_cnt + 8'(hold_cnt != 8'hff) : 8'h01;
    if ({pins_out.cs_n, pins_out.ras_n, pins_out.cas_n, pins_out.we_n} == 4'h0)
      mrs_cnt <= 8'h00;
    else
      mrs_cnt <= mrs_cnt + 8'(mrs_cnt != 8'hff);
    if (!busy)
    begin
      pins_out.addr <= ~pins_out.addr;
      pins_out.ras_n <= ~pins_out.ras_n;
    end
  end

  // ----------------------------------------
  // one command for one edge, then deselect
  // ----------------------------------------
  task automatic send(input logic cke, input logic cs_n, input logic [2:0] rcw,
                      input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] addr);
    logic old;
    @(posedge clk_in);
    if (woke)
      repeat (XS_CYC) @(posedge clk_in);
    woke = 1'b0;
    while (mrs_cnt <= MRD_CYC) @(posedge clk_in);
    while (cke != pins_out.cke && hold_cnt <= CKE_MIN_CYC) @(posedge clk_in);
    old = pins_out.cke;
    busy = 1'b1;
    pins_out <= '{cke, cs_n, rcw[2], rcw[1], rcw[0], ba, addr};
    @(posedge clk_in);
    busy = 1'b0;
    pins_out.cs_n <= 1'b1;
    woke = cke & ~old;
  endtask : send

  // ----------------------------------------
  // deliberate short enable dip
  // ----------------------------------------
  // breaks the minimum hold on purpose, only to prove the device flags it
  task automatic cke_dip();
    @(posedge clk_in);
    pins_out.cke <= 1'b0;
    @(posedge clk_in);
    pins_out.cke <= 1'b1;
    @(posedge clk_in);
  endtask : cke_dip
endmodule : dcd_ctrl_model
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the command decode and clock-enable block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dcd_pkg::*;
  logic        clk, rst, odt, otf, fchop, ilv, bopen;  // bench-driven inputs
  dcd_pins_t   pins;                                   // pins from the controller model
  logic        cv, cap, cchop, bact, bwr, dqoe, odta, herr, mbusy;
  logic [3:0]  code;
  logic [2:0]  cba, bcol;
  logic [15:0] caddr;
  logic [1:0]  pwr;
  int          miscompares, cmp_count;

  dcd_ctrl_model dcd_ctrl_model_i (.clk_in(clk), .pins_out(pins));
  dcd_core dcd_core_i (.CORE_CLK_IN(clk), .RST_IN(rst), .CKE_IN(pins.cke),
    .CS_N_IN(pins.cs_n), .RAS_N_IN(pins.ras_n), .CAS_N_IN(pins.cas_n), .WE_N_IN(pins.we_n),
    .BA_IN(pins.ba), .ADDR_IN(pins.addr), .ODT_IN(odt), .OTF_EN_IN(otf),
    .FIXED_CHOP_IN(fchop), .INTERLEAVE_IN(ilv), .BANKS_OPEN_IN(bopen),
    .CMD_VALID_OUT(cv), .CMD_CODE_OUT(code), .CMD_BA_OUT(cba), .CMD_ADDR_OUT(caddr),
    .CMD_AP_OUT(cap), .CMD_CHOP_OUT(cchop), .BURST_ACTIVE_OUT(bact),
    .BURST_WRITE_OUT(bwr), .DQ_OE_OUT(dqoe), .BURST_COL_OUT(bcol),
    .PWR_STATE_OUT(pwr), .ODT_ACTIVE_OUT(odta), .CKE_HOLD_ERR_OUT(herr),
    .MRD_BUSY_OUT(mbusy));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // compare, expectation and stimulus tasks
  // ----------------------------------------
  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  // expected code for a command with enable high on both edges
  function automatic logic [3:0] dec(input logic [2:0] rcw, input logic a10);
    case (rcw)
      3'h0: dec = DCD_CMD_MRS;
      3'h1: dec = DCD_CMD_REF;
      3'h2: dec = a10 ? DCD_CMD_PREA : DCD_CMD_PRE;
      3'h3: dec = DCD_CMD_ACT;
      3'h4: dec = DCD_CMD_WR;
      3'h5: dec = DCD_CMD_RD;
      3'h6: dec = a10 ? DCD_CMD_ZQL : DCD_CMD_ZQS;
      default: dec = DCD_CMD_NOP;
    endcase
  endfunction : dec

  // send one command and look for its decode pulse; a no-op code means none
  task automatic cmd(input logic ck, input logic cs, input logic [2:0] rcw,
                     input logic [2:0] ba, input logic [15:0] a, input logic [3:0] ex);
    logic seen;
    dcd_ctrl_model_i.send(ck, cs, rcw, ba, a);
    seen = 1'b0;
    repeat (6)
    begin
      @(posedge clk);
      #1;
      if (cv === 1'b1)
        break;
    end
    seen = (cv === 1'b1);
    cmp_val("valid", 16'(ex != 4'h0), 16'(seen));
    if (seen)
    begin
      cmp_val("code", ex, code);
      if (ex < 4'ha)
        cmp_val("bank addr", {ba, a[12:0]}, {cba, caddr[12:0]});
      if (ex < 4'ha)
        cmp_val("auto precharge", a[10], cap);
      if (ex == 4'h8 || ex == 4'h9)
        cmp_val("chop", otf ? !a[12] : fchop, cchop);
    end
  endtask : cmd

  // follow the eight beat slots of a burst already started
  task automatic chk_burst(input logic [2:0] s, input logic il, input logic ch, input logic wr);
    logic [2:0] c;
    for (int k = 0; k < 8; k++)
    begin
      c = wr ? {ch & s[2], 2'b00} + 3'(k) :
               {s[2] ^ k[2], il ? s[1:0] ^ k[1:0] : s[1:0] + k[1:0]};
      cmp_val("active", 1, bact);
      cmp_val("write", wr, bwr);
      if (!(wr && ch && k > 3))
        cmp_val("column", c, bcol);
      cmp_val("drive", 16'(!wr && !(ch && k > 3)), dqoe);
      @(posedge clk);
      #1;
    end
    cmp_val("active end", 0, bact);
  endtask : chk_burst

  // read or write from start column s; low address bits around it random
  task automatic rw(input logic wr, input logic [2:0] s, input logic a12, input logic a10);
    logic [15:0] a;
    a = (16'($urandom) & 16'hebf8) | {3'h0, a12, 1'b0, a10, 7'h0, s};
    cmd(1'b1, 1'b0, wr ? 3'h4 : 3'h5, 3'($urandom), a, wr ? 4'h8 : 4'h9);
    chk_burst(s, ilv, otf ? !a12 : fchop, wr);
  endtask : rw

  task automatic chk_pwr(input logic [1:0] ex);
    repeat (2) @(posedge clk);
    #1;
    cmp_val("power state", ex, pwr);
  endtask : chk_pwr

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {rst, odt, otf, fchop, ilv, bopen} = 6'h28;
    miscompares = 0;
    cmp_count = 0;
    void'($urandom(72));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    // every command code, both address bit 10 levels, deselect at the end
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk) odt <= 1'($urandom);
      cmd(1'b1, 1'(i == 15), 3'(i), 3'($urandom), {5'($urandom), i[3], 10'($urandom)},
          dec(3'(i), i[3]));
      if (i[2:0] == 3'h0)
      begin
        @(posedge clk);
        #1;
        cmp_val("mode busy", 1, mbusy);
        repeat (4) @(posedge clk);
        #1;
        cmp_val("mode idle", 0, mbusy);
      end
      repeat (10) @(posedge clk);
    end
    // all start columns, both orders, chop and full reads
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk) ilv <= i[3];
      rw(1'b0, 3'(i), i[4], 1'($urandom));
    end
    for (int i = 0; i < 8; i++)
      rw(1'b1, 3'($urandom), i[0], i[1]);
    // fixed length: bit 12 set to agree with the fixed choice
    for (int j = 0; j < 4; j++)
    begin
      @(posedge clk) {otf, fchop} <= {1'b0, j[0]};
      rw(j[1], 3'($urandom), !j[0], 1'b0);
    end
    @(posedge clk) otf <= 1'b1;
    // a write right behind a read must not cut the read short
    cmd(1'b1, 1'b0, 3'h5, 3'h0, 16'h1005, DCD_CMD_RD);
    fork
      chk_burst(3'h5, ilv, 1'b0, 1'b0);
      dcd_ctrl_model_i.send(1'b1, 1'b0, 3'h4, 3'h1, 16'h0002);
    join
    repeat (4)
    begin
      @(posedge clk);
      #1;
      cmp_val("no restart", 0, bact);
    end
    // power down from closed and open banks, pins ignored while low
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk) bopen <= i[0];
      cmd(1'b0, i[0], 3'h7, 3'h0, 16'h0000, DCD_CMD_PDE);
      chk_pwr(i[0] ? DCD_PWR_APD : DCD_PWR_PPD);
      repeat (3)
        cmd(1'b0, 1'($urandom), 3'($urandom), 3'h0, 16'($urandom), DCD_CMD_NOP);
      chk_pwr(i[0] ? DCD_PWR_APD : DCD_PWR_PPD);
      cmd(1'b1, !i[0], 3'h7, 3'h0, 16'h0000, DCD_CMD_PDX);
      chk_pwr(DCD_PWR_ON);
    end
    // self refresh with termination requested throughout
    @(posedge clk) {bopen, odt} <= 2'h1;
    cmd(1'b0, 1'b0, 3'h1, 3'h0, 16'h0000, DCD_CMD_SRE);
    chk_pwr(DCD_PWR_SR);
    cmp_val("termination off", 0, odta);
    cmd(1'b0, 1'b0, 3'h5, 3'h0, 16'h0000, DCD_CMD_NOP);
    cmd(1'b1, 1'b0, 3'h7, 3'h0, 16'h0000, DCD_CMD_SRX);
    chk_pwr(DCD_PWR_ON);
    cmp_val("termination on", 1, odta);
    cmp_val("hold error", 0, herr);
    // a one-edge dip of enable is too short and must be flagged
    dcd_ctrl_model_i.cke_dip();
    repeat (4) @(posedge clk);
    #1;
    cmp_val("hold error set", 1, herr);
    tally_and_finish();
  end

  // watchdog: the whole run needs well under 5000 cycles
  initial
  begin
    #(50 * 5000);
    miscompares++;
    $display("[ERR] watchdog expected finish seen hang");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
